// *** logic/dec_out_pkg.sv ***
// Package with register map, field layout and types for the decimation output formatter.
`default_nettype none
package dec_out_pkg;
    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] LEVEL_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS  = 8'h08;
    // Control field positions.
    localparam int CTRL_MULTI_BIT = 0;
    localparam int CTRL_TAG24_BIT = 1;
    localparam int CTRL_HALVE_BIT = 2;
    localparam int CTRL_OSC_BIT   = 3;
    localparam int CTRL_GNDIN_BIT = 4;
    localparam int CTRL_SHGND_BIT = 5;
    localparam int CTRL_RUN_BIT   = 6;
    localparam int CTRL_CPLX_BIT  = 7;
    localparam int CTRL_P16_BIT   = 8;
    // Reset values.
    localparam logic [8:0] CTRL_RESET  = 9'h000;
    localparam logic [4:0] LEVEL_RESET = 5'h00;
    // Decimation limits.
    localparam logic [4:0] LEVEL_MAX   = 5'h18;
    localparam logic [4:0] LEVEL_HALVE = 5'h17;
    // Tag layout.
    localparam int TAG_W       = 5;
    localparam int TAG24_LSB   = 8;

    typedef struct packed {
        logic       valid;
        logic [4:0] stage;
        logic [31:0] data;
    } sample_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] word;
    } word_out_t;

    typedef struct packed {
        logic [8:0]  ctrl;
        logic [4:0]  data_level;
        logic [4:0]  trig_level;
        logic        running;
        logic        dropped_idle;
        logic        phase;
        logic        tag_pend;
        logic [4:0]  pend_tag;
        logic        hsel_d;
        logic        hwrite_d;
        logic [7:0]  haddr_d;
        logic [31:0] hrdata;
        word_out_t   out;
    } state_t;
endpackage
`default_nettype wire

// *** logic/dec_out_cfg.sv ***
// Decimation output configuration, tag formatting and AHB-Lite control registers.
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module dec_out_cfg
    import dec_out_pkg::*;
(
    // Clock and reset.
    input  wire  logic                  sys_clk,
    input  wire  logic                  rst_b,
    // AHB-Lite slave.
    input  wire  logic                  hsel,
    input  wire  logic [31:0]           haddr,
    input  wire  logic [1:0]            htrans,
    input  wire  logic                  hwrite,
    input  wire  logic [2:0]            hsize,
    input  wire  logic [31:0]           hwdata,
    input  wire  logic                  hready,
    output var   logic [31:0]           hrdata,
    output var   logic                  hreadyout,
    output var   logic                  hresp,
    // Sample stream from the cascade and formatted word stream out.
    input  wire  dec_out_pkg::sample_t  sample_in,
    output var   dec_out_pkg::word_out_t word_out,
    // Input path and clock selects, and the idle flag.
    output var   logic                  processing_clock_from_oscillator,
    output var   logic                  converter_input_grounded,
    output var   logic                  shield_to_chassis,
    output var   logic                  acq_idle
);
    import dec_out_pkg::*;

    state_t s_reg;
    state_t s_next;

    logic       multi_eff;
    logic       tag24;
    logic       wr_ctrl;
    logic       wr_level;
    logic [8:0] new_ctrl;
    logic       take_sample;

    // Clamp a level: never above 24, and never above 23 while halving.
    function automatic logic [4:0] clamp_level(input logic [4:0] lvl, input logic halve);
        logic [4:0] r;
        r = (lvl > LEVEL_MAX) ? LEVEL_MAX : lvl;
        if (halve && (r > LEVEL_HALVE))
        begin
            r = LEVEL_HALVE;
        end
        return r;
    endfunction

    // Place the tag into a 32-bit word per precision, type and position.
    function automatic logic [31:0] fmt_word(input logic [31:0] d, input logic [4:0] t,
                                             input logic p16, input logic cplx, input logic t24);
        logic [31:0] w;
        w = d;
        if (p16)
        begin
            w = cplx ? {d[31:16], d[15:5], t} : {d[31:16], 11'h000, t};
        end
        else if (!cplx)
        begin
            if (t24)
            begin
                w = {d[31:13], t, d[7:0]};
            end
            else
            begin
                w = {d[31:5], t};
            end
        end
        return w;
    endfunction

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = s_reg.hrdata;
    assign word_out  = s_reg.out;

    assign processing_clock_from_oscillator = s_reg.ctrl[CTRL_OSC_BIT];
    assign converter_input_grounded = s_reg.ctrl[CTRL_GNDIN_BIT];
    assign shield_to_chassis = s_reg.ctrl[CTRL_SHGND_BIT];
    assign acq_idle = !s_reg.running;

    assign multi_eff = s_reg.ctrl[CTRL_MULTI_BIT] && (s_reg.data_level == 5'h00);
    assign tag24     = s_reg.ctrl[CTRL_TAG24_BIT];
    assign wr_ctrl   = s_reg.hsel_d && s_reg.hwrite_d && (s_reg.haddr_d == CTRL_OFS);
    assign wr_level  = s_reg.hsel_d && s_reg.hwrite_d && (s_reg.haddr_d == LEVEL_OFS);
    assign new_ctrl  = hwdata[8:0];
    // A sample accepted this cycle with halving off; the checks below key on it.
    assign take_sample = s_reg.running && sample_in.valid && !s_reg.tag_pend && !s_reg.ctrl[CTRL_HALVE_BIT];

    // Next-state logic: bus, control and the formatting pipeline.
    always_comb
    begin
        s_next = s_reg;
        s_next.out.valid = 1'b0;
        s_next.hsel_d = hsel && hready && htrans[1];
        if (hsel && hready && htrans[1])
        begin
            s_next.hwrite_d = hwrite;
            s_next.haddr_d  = haddr[7:0];
        end
        if (wr_ctrl)
        begin
            s_next.ctrl    = new_ctrl;
            s_next.running = new_ctrl[CTRL_RUN_BIT];
            s_next.dropped_idle = 1'b0;
            if (s_reg.running && ((new_ctrl[CTRL_HALVE_BIT] != s_reg.ctrl[CTRL_HALVE_BIT]) ||
                                  (new_ctrl[CTRL_TAG24_BIT] != s_reg.ctrl[CTRL_TAG24_BIT])))
            begin
                s_next.running = 1'b0;
                s_next.ctrl[CTRL_RUN_BIT] = 1'b0;
                s_next.dropped_idle = 1'b1;
            end
            s_next.data_level = clamp_level(s_reg.data_level, new_ctrl[CTRL_HALVE_BIT]);
            s_next.trig_level = clamp_level(s_reg.trig_level, new_ctrl[CTRL_HALVE_BIT]);
            s_next.phase = 1'b0;
        end
        else if (wr_level)
        begin
            s_next.data_level = clamp_level(hwdata[4:0], s_reg.ctrl[CTRL_HALVE_BIT]);
            s_next.trig_level = clamp_level(hwdata[12:8], s_reg.ctrl[CTRL_HALVE_BIT]);
        end
        // Read data for the next data phase; unmapped reads return zero.
        s_next.hrdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            case (haddr[7:0])
                CTRL_OFS:   s_next.hrdata = {23'h0, s_next.ctrl};
                LEVEL_OFS:  s_next.hrdata = {19'h0, s_next.trig_level, 3'h0, s_next.data_level};
                STATUS_OFS: s_next.hrdata = {30'h0, s_next.dropped_idle, s_next.running};
                default:    s_next.hrdata = 32'h0000_0000;
            endcase
        end
        if (s_reg.tag_pend)
        begin
            s_next.out.valid = 1'b1;
            s_next.out.word  = {27'h0, s_reg.pend_tag};
            s_next.tag_pend  = 1'b0;
        end
        else if (s_reg.running && sample_in.valid)
        begin
            // identical results on either clock, same datapath
            if (s_reg.ctrl[CTRL_HALVE_BIT])
            begin
                s_next.phase = !s_reg.phase;
            end
            // forward every sample when not halving; a sample that arrives while a tag word is pending is dropped
            if (!s_reg.ctrl[CTRL_HALVE_BIT] || !s_reg.phase)
            begin
                s_next.out.valid = 1'b1;
                if (multi_eff)
                begin
                    // overwrite five data bits at 32-bit real; 32-bit complex passes unchanged
                    s_next.out.word = fmt_word(sample_in.data, sample_in.stage,
                                               s_reg.ctrl[CTRL_P16_BIT], s_reg.ctrl[CTRL_CPLX_BIT], tag24);
                    if (s_reg.ctrl[CTRL_P16_BIT])
                    begin
                        s_next.tag_pend = 1'b1;
                        s_next.pend_tag = sample_in.stage;
                    end
                end
                else
                begin
                    s_next.out.word = sample_in.data;
                end
            end
        end
    end

    // State register.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    a_level_cap: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (s_reg.data_level <= LEVEL_MAX) && (s_reg.trig_level <= LEVEL_MAX))
        else $error("level above cap");

    a_halve_level: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_reg.ctrl[CTRL_HALVE_BIT] |-> ((s_reg.data_level <= LEVEL_HALVE) && (s_reg.trig_level <= LEVEL_HALVE)))
        else $error("halving level high");

    a_idle_drop: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_ctrl && s_reg.running && ((new_ctrl[CTRL_TAG24_BIT] != tag24) ||
         (new_ctrl[CTRL_HALVE_BIT] != s_reg.ctrl[CTRL_HALVE_BIT]))) |=> (!s_reg.running && s_reg.dropped_idle))
        else $error("no idle drop");

    a_tag_word: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_reg.tag_pend |=> (s_reg.out.valid && (s_reg.out.word[31:5] == 27'h0)))
        else $error("tag word missing");

    a_tag_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (take_sample && multi_eff && s_reg.ctrl[CTRL_P16_BIT])
        |-> ##2 (s_reg.out.valid && (s_reg.out.word == {27'h0, $past(sample_in.stage, 2)})))
        else $error("tag word late");

    a_halve_rate: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (s_reg.running && s_reg.ctrl[CTRL_HALVE_BIT] && !s_reg.ctrl[CTRL_MULTI_BIT] && s_reg.out.valid)
        |=> !s_reg.out.valid)
        else $error("halving passed adjacent");

    a_untagged: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (take_sample && !multi_eff && !wr_ctrl)
        |=> (s_reg.out.valid && (s_reg.out.word == $past(sample_in.data))))
        else $error("untagged mismatch");

    a_tag_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (take_sample && multi_eff && !tag24 && !s_reg.ctrl[CTRL_P16_BIT] && !s_reg.ctrl[CTRL_CPLX_BIT])
        |=> (s_reg.out.word == {$past(sample_in.data[31:5]), $past(sample_in.stage)}))
        else $error("tag low wrong");

    a_tag_upper: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (take_sample && multi_eff && tag24 && !s_reg.ctrl[CTRL_P16_BIT] && !s_reg.ctrl[CTRL_CPLX_BIT])
        |=> (s_reg.out.word == {$past(sample_in.data[31:13]), $past(sample_in.stage), $past(sample_in.data[7:0])}))
        else $error("tag upper wrong");

    a_tag_lsb: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (take_sample && multi_eff && !tag24 && !(s_reg.ctrl[CTRL_CPLX_BIT] && !s_reg.ctrl[CTRL_P16_BIT]))
        |=> (s_reg.out.word[4:0] == $past(sample_in.stage)))
        else $error("tag lsb wrong");

    a_tag_overwrite: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (take_sample && multi_eff && !s_reg.ctrl[CTRL_P16_BIT])
        |=> ($countones(s_reg.out.word ^ $past(sample_in.data)) <= 5))
        else $error("too many bits changed");

    a_p16_real: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (take_sample && multi_eff && s_reg.ctrl[CTRL_P16_BIT] && !s_reg.ctrl[CTRL_CPLX_BIT])
        |=> (s_reg.out.word == {$past(sample_in.data[31:16]), 11'h0, $past(sample_in.stage)}))
        else $error("real 16-bit layout wrong");

    a_p16_cplx: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (take_sample && multi_eff && s_reg.ctrl[CTRL_P16_BIT] && s_reg.ctrl[CTRL_CPLX_BIT])
        |=> (s_reg.out.word == {$past(sample_in.data[31:5]), $past(sample_in.stage)}))
        else $error("complex 16-bit layout wrong");

    a_stage_out: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (take_sample && multi_eff)
        |=> s_reg.out.valid)
        else $error("stage sample lost");

    a_tag_reset: assert property (@(posedge sys_clk)
        $rose(rst_b) |-> (!s_reg.ctrl[CTRL_TAG24_BIT] && !s_reg.running))
        else $error("tag position not default");

    a_every_sample: assert property (@(posedge sys_clk) disable iff (!rst_b)
        take_sample
        |=> s_reg.out.valid)
        else $error("sample not forwarded");

    a_multi_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (take_sample && (s_reg.data_level != 5'h00))
        |=> (s_reg.out.word == $past(sample_in.data)))
        else $error("tag at nonzero level");

    a_osc_sel: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_ctrl
        |=> (processing_clock_from_oscillator == $past(new_ctrl[CTRL_OSC_BIT])))
        else $error("clock select wrong");

    a_input_sel: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_ctrl
        |=> (converter_input_grounded == $past(new_ctrl[CTRL_GNDIN_BIT])))
        else $error("input select wrong");

    a_shield_sel: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_ctrl
        |=> (shield_to_chassis == $past(new_ctrl[CTRL_SHGND_BIT])))
        else $error("shield select wrong");

    a_clock_same: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (take_sample && s_reg.ctrl[CTRL_OSC_BIT] && !multi_eff)
        |=> (s_reg.out.word == $past(sample_in.data)))
        else $error("oscillator changed data");
endmodule
`default_nettype wire

// *** tb/word_reader.sv ***
// Model of the host controller that reads formatted sample words from the formatter.
`timescale 1ns/1ps
`default_nettype none
module word_reader
    import dec_out_pkg::*;
(
    // Clock and reset.
    input  wire logic                   sys_clk,
    input  wire logic                   rst_b,
    // Formatted word stream.
    input  wire dec_out_pkg::word_out_t word_out
);
    // Words in arrival order; the bench empties it before each scenario that checks it (format, halving, level).
    logic [31:0] words [$];

    // Take a word on every rising edge, out of reset, where the stream says it is valid.
    always @(posedge sys_clk)
    begin
        if (rst_b === 1'b1 && word_out.valid === 1'b1)
            words.push_back(word_out.word);
    end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking testbench for the decimation output formatter.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dec_out_pkg::*;
    logic        sys_clk;
    logic        rst_b;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    sample_t     sample_in;
    word_out_t   word_out;
    logic        osc_sel;
    logic        gnd_in;
    logic        sh_gnd;
    logic        acq_idle;
    int          n_mismatch;
    int          check_count;
    logic [31:0] rd;
    logic [8:0]  modes [8] = '{9'h040, 9'h042, 9'h041, 9'h043, 9'h0C1, 9'h141, 9'h1C1, 9'h049};

    dec_out_cfg dec_out_cfg_inst (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sample_in(sample_in), .word_out(word_out),
        .processing_clock_from_oscillator(osc_sel), .converter_input_grounded(gnd_in),
        .shield_to_chassis(sh_gnd), .acq_idle(acq_idle));
    word_reader word_reader_inst (.sys_clk(sys_clk), .rst_b(rst_b), .word_out(word_out));

    // Free-running system clock.
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One single AHB-Lite transfer; the master holds each phase until hready is seen high.
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask

    // Samples are spaced so a pending tag word never collides with the next sample.
    task send(input logic [4:0] s, input logic [31:0] d);
        @(posedge sys_clk);
        sample_in <= '{1'b1, s, d};
        @(posedge sys_clk);
        sample_in <= '{1'b0, s, d};
        repeat (3) @(posedge sys_clk);
    endtask

    task t_reset;
        rdchk("ctrl_rst", CTRL_OFS, 32'h0);
        rdchk("level_rst", LEVEL_OFS, 32'h0);
        ahb(1'b1, 8'h0C, 32'hFFFFFFFF);
        rdchk("unmapped", 8'h0C, 32'h0);
        check("idle_rst", {31'h0, acq_idle}, 32'h1);
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task t_selects;
        for (int k = 0; k < 3; k++)
        begin
            ahb(1'b1, CTRL_OFS, 32'h8 << k);
            @(negedge sys_clk);
            check("selects", {29'h0, sh_gnd, gnd_in, osc_sel}, 32'h1 << k);
        end
        ahb(1'b1, CTRL_OFS, 32'h0);
    endtask

    task t_format;
        logic [31:0] e;
        logic [4:0]  s;
        logic [8:0]  m;
        for (int i = 0; i < 8; i++)
        begin
            m = modes[i];
            s = 5'(i + 17);
            ahb(1'b1, CTRL_OFS, 32'h0);
            ahb(1'b1, CTRL_OFS, {23'h0, m});
            word_reader_inst.words.delete();
            send(s, 32'hA5C39E7F);
            e = 32'hA5C39E7F;
            if (m[0] && !m[8] && !m[7])
            begin
                if (m[1])
                    e[12:8] = s;
                else
                    e[4:0] = s;
            end
            else if (m[0] && m[8])
                e = m[7] ? {e[31:16], e[15:5], s} : {e[31:16], 11'h0, s};
            check("fmt_count", 32'(word_reader_inst.words.size()), (m[0] && m[8]) ? 32'h2 : 32'h1);
            check("fmt_word", word_reader_inst.words[0], e);
            if (m[0] && m[8])
                check("fmt_tag", word_reader_inst.words[1], {27'h0, s});
        end
    endtask

    task t_halve;
        for (int h = 0; h < 2; h++)
        begin
            ahb(1'b1, CTRL_OFS, 32'h0);
            ahb(1'b1, CTRL_OFS, h ? 32'h44 : 32'h40);
            word_reader_inst.words.delete();
            for (int j = 0; j < 4; j++)
                send(5'h0, 32'h1000 + j);
            check("halve_count", 32'(word_reader_inst.words.size()), h ? 32'h2 : 32'h4);
            check("halve_word", word_reader_inst.words[1], h ? 32'h1002 : 32'h1001);
        end
    endtask

    task t_idle;
        for (int b = 1; b < 3; b++)
        begin
            ahb(1'b1, CTRL_OFS, 32'h0);
            ahb(1'b1, CTRL_OFS, 32'h40);
            @(negedge sys_clk);
            check("running", {31'h0, acq_idle}, 32'h0);
            ahb(1'b1, CTRL_OFS, 32'h40 | (32'h1 << b));
            @(negedge sys_clk);
            check("drop_idle", {31'h0, acq_idle}, 32'h1);
            rdchk("drop_status", STATUS_OFS, 32'h2);
        end
    endtask

    task t_level;
        ahb(1'b1, CTRL_OFS, 32'h0);
        ahb(1'b1, LEVEL_OFS, 32'h1F1F);
        rdchk("level_clamp", LEVEL_OFS, 32'h1818);
        ahb(1'b1, CTRL_OFS, 32'h4);
        rdchk("level_halve", LEVEL_OFS, 32'h1717);
        ahb(1'b1, LEVEL_OFS, 32'h1818);
        rdchk("level_total", LEVEL_OFS, 32'h1717);
        ahb(1'b1, LEVEL_OFS, 32'h1);
        ahb(1'b1, CTRL_OFS, 32'h0);
        ahb(1'b1, CTRL_OFS, 32'h41);
        word_reader_inst.words.delete();
        send(5'h7, 32'h0F0F0F0F);
        check("multi_level", word_reader_inst.words[0], 32'h0F0F0F0F);
    endtask

    task print_verdict;
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // A hang counts as a mismatch and ends the run the usual way.
    initial
    begin
        #200000;
        n_mismatch++;
        print_verdict();
    end

    // Main sequence: reset, then one scenario after another.
    initial
    begin
        n_mismatch = 0;
        check_count = 0;
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        sample_in = '0;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_selects();
        t_format();
        t_halve();
        t_idle();
        t_level();
        print_verdict();
    end
endmodule
`default_nettype wire
